// File: verilog/ctmc_ctrl.sv
// APB-mapped control, edge sequencing and current steering of the charge time measurement block.
`timescale 1ns/10ps
// Contract
// - Enable bit 15 turns the unit on; cleared stops edges, current, delay and trigger; source-ground bit 9, trim, range and flag writes stay live.
// - Idle-stop bit 13 halts the unit while the device is idle.
// - Delay-generation bit 12 steers current to comparator input B.
// - Delay mode charges on an edge, pulses when comparator trips.
// - Edge gate bit 11 passes edges when set, blocks them when cleared.
// - Edge-order bit 10 ignores second edge until first edge occurred.
// - Source-ground bit 9 grounds the current source output.
// - Trigger enable bit 8 allows the trigger output.
// - Six-bit trim field is a signed offset from nominal current.
// - Current goes to the diode only while both edge flags match.
// - Each edge input selects timer, output compare or 13 external pins.
// - Edge flags set by hardware, and software may write them.
module ctmc_ctrl #(
    parameter int EXT_PINS = ctmc_pkg::CTMC_EXT_PINS
) (
    input wire logic clk_sys_i,           // System clock, 200 MHz.
    input wire logic rstn_i,              // Asynchronous reset, active low.
    input wire logic psel,                // APB select.
    input wire logic penable,             // APB enable.
    input wire logic pwrite,              // APB write.
    input wire logic [11:0] paddr,        // APB byte address.
    input wire logic [31:0] pwdata,       // APB write data.
    input wire logic [3:0] pstrb,         // APB byte strobes.
    output logic [31:0] prdata,           // APB read data.
    output logic pready,                  // APB ready.
    output logic pslverr,                 // APB error on unmapped address.
    input wire logic idle_mode_i,         // Device is in idle mode.
    input wire logic timer_match_i,       // Timer match edge source.
    input wire logic ocmp_event_i,        // Output compare edge source.
    input wire logic [EXT_PINS-1:0] ext_edge_pin_i, // External edge pins.
    input wire logic comp2_trip_i,        // Comparator reports trip level crossed.
    output logic current_on_o,            // Current source switched on.
    output logic source_ground_o,         // Current source output grounded.
    output ctmc_pkg::ctmc_route_t route_o, // Current routing.
    output logic [ctmc_pkg::CTMC_TRIM_W-1:0] current_trim_o,   // Signed trim.
    output logic [ctmc_pkg::CTMC_RANGE_W-1:0] current_range_o, // Range code.
    output logic delay_pulse_out_o,       // Delay pulse output.
    output logic trigger_o,               // Trigger output.
    output logic first_edge_flag_o,       // First edge status.
    output logic second_edge_flag_o       // Second edge status.
);
    import ctmc_pkg::*;

    logic [15:0] ctrl;
    logic [9:0] edge_cfg;
    logic [1:0] ev_ch;
    logic flag1;
    logic flag2;
    logic ev1;
    logic ev2;
    logic run;
    logic wr;
    logic rd_hit;
    logic [CTMC_EDGE_SRC_N-1:0] srcs;
    ctmc_dly_state_t dly_state;
    logic pulse;
    logic trig;
    logic [31:0] rdata;

    assign wr = psel & penable & pwrite;
    assign pready = 1'b1;
    assign rd_hit = (paddr == CTMC_ADDR_CTRL) || (paddr == CTMC_ADDR_EDGE) || (paddr == CTMC_ADDR_STAT);
    assign pslverr = psel & penable & ~rd_hit;

    // Unit runs only when enabled and not stopped by idle.
    assign run = ctrl[CTMC_BIT_ENABLE] & ~(ctrl[CTMC_BIT_IDLE_STOP] & idle_mode_i);

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl <= CTMC_CTRL_RESET;
        end else if (wr && paddr == CTMC_ADDR_CTRL) begin
            if (pstrb[0]) begin
                ctrl[7:0] <= pwdata[7:0] & CTMC_CTRL_WMASK[7:0];
            end
            if (pstrb[1]) begin
                ctrl[15:8] <= pwdata[15:8] & CTMC_CTRL_WMASK[15:8];
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            edge_cfg <= 10'h000;
        end else if (wr && paddr == CTMC_ADDR_EDGE) begin
            if (pstrb[0]) begin
                edge_cfg[7:0] <= pwdata[7:0];
            end
            if (pstrb[1]) begin
                edge_cfg[9:8] <= pwdata[9:8];
            end
        end
    end

    // Source 0 is the timer, 1 the output compare, then the external pins.
    assign srcs = {{(CTMC_EDGE_SRC_N-2-EXT_PINS){1'b0}}, ext_edge_pin_i, ocmp_event_i, timer_match_i};

    // One detector per edge channel; channel 0 feeds the first flag and channel 1 the second.
    for (genvar ch = 0; ch < 2; ch++) begin : g_edge
        ctmc_edge_det #(.SRC_N(CTMC_EDGE_SRC_N)) u_det (
            .clk_sys_i(clk_sys_i),
            .rstn_i(rstn_i),
            .src_i(srcs),
            .sel_i(edge_cfg[CTMC_EDGE1_SEL_LSB + ch * CTMC_EDGE_SEL_W +: CTMC_EDGE_SEL_W]),
            .pos_i(edge_cfg[CTMC_EDGE1_POL + ch]),
            .event_o(ev_ch[ch])
        );
    end

    assign ev1 = ev_ch[0];
    assign ev2 = ev_ch[1];

    logic acc1;
    logic acc2;
    logic flag_wr;
    assign acc1 = run & ctrl[CTMC_BIT_EDGE_GATE] & ev1;
    // With ordering on, the second edge counts only after the first flag is set.
    assign acc2 = run & ctrl[CTMC_BIT_EDGE_GATE] & ev2 & (~ctrl[CTMC_BIT_EDGE_ORDER] | flag1);
    assign flag_wr = wr && paddr == CTMC_ADDR_EDGE && pstrb[1];

    // Hardware set wins over a software write in the same cycle.
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            flag1 <= 1'b0;
            flag2 <= 1'b0;
        end else begin
            if (acc1) begin
                flag1 <= 1'b1;
            end else if (flag_wr) begin
                flag1 <= pwdata[CTMC_EDGE1_FLAG];
            end
            if (acc2) begin
                flag2 <= 1'b1;
            end else if (flag_wr) begin
                flag2 <= pwdata[CTMC_EDGE2_FLAG];
            end
        end
    end

    // Delay generator: charge from an accepted edge until the comparator trips.
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dly_state <= CTMC_DLY_IDLE;
        end else if (!run || !ctrl[CTMC_BIT_DELAY_GEN]) begin
            dly_state <= CTMC_DLY_IDLE;
        end else begin
            case (dly_state)
                CTMC_DLY_IDLE: begin
                    if (acc1 || acc2) begin
                        dly_state <= CTMC_DLY_CHARGE;
                    end
                end
                CTMC_DLY_CHARGE: begin
                    if (comp2_trip_i) begin
                        dly_state <= CTMC_DLY_PULSE;
                    end
                end
                CTMC_DLY_PULSE: begin
                    if (!comp2_trip_i) begin
                        dly_state <= CTMC_DLY_IDLE;
                    end
                end
                default: begin
                    dly_state <= CTMC_DLY_IDLE;
                end
            endcase
        end
    end

    // The delay pulse stands for the one cycle after the comparator trips while charging.
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pulse <= 1'b0;
        end else begin
            pulse <= run & ctrl[CTMC_BIT_DELAY_GEN] & (dly_state == CTMC_DLY_CHARGE) & comp2_trip_i;
        end
    end

    // The trigger follows the window between the two edges when it is allowed.
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            trig <= 1'b0;
        end else begin
            trig <= run & ctrl[CTMC_BIT_TRIG_EN] & (flag1 ^ flag2);
        end
    end
    assign delay_pulse_out_o = pulse;
    assign trigger_o = trig;

    always_comb begin
        if (!run) begin
            route_o = CTMC_ROUTE_OFF;
        end else if (flag1 == flag2) begin
            route_o = CTMC_ROUTE_DIODE;
        end else if (ctrl[CTMC_BIT_DELAY_GEN]) begin
            route_o = CTMC_ROUTE_COMP;
        end else begin
            route_o = CTMC_ROUTE_ADC;
        end
    end

    assign current_on_o = run & ((flag1 ^ flag2) | (dly_state == CTMC_DLY_CHARGE));
    assign source_ground_o = ctrl[CTMC_BIT_SRC_GROUND];
    assign current_trim_o = ctrl[CTMC_TRIM_LSB +: CTMC_TRIM_W];
    assign current_range_o = ctrl[CTMC_RANGE_LSB +: CTMC_RANGE_W];
    assign first_edge_flag_o = flag1;
    assign second_edge_flag_o = flag2;

    always_comb begin
        rdata = 32'h0000_0000;
        case (paddr)
            CTMC_ADDR_CTRL: rdata = {16'h0000, ctrl};
            CTMC_ADDR_EDGE: rdata = {20'h00000, flag2, flag1, edge_cfg[9:0]};
            CTMC_ADDR_STAT: rdata = {28'h0000000, pulse, run, 2'(dly_state)};
            default: rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rdata;
        end
    end

    // Checks of the control rules; all of them rest while reset is applied.
    AST_DISABLED_NO_CURRENT: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        !ctrl[CTMC_BIT_ENABLE] |-> !current_on_o && route_o == CTMC_ROUTE_OFF)
        else $error("current while disabled");

    AST_DISABLED_NO_OUTPUTS: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        !ctrl[CTMC_BIT_ENABLE] |=> !trigger_o && !pulse)
        else $error("outputs while disabled");

    AST_RUN_WHEN_ENABLED: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        ctrl[CTMC_BIT_ENABLE] && !ctrl[CTMC_BIT_IDLE_STOP] |-> run)
        else $error("enabled unit not running");

    AST_IDLE_STOP: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        ctrl[CTMC_BIT_IDLE_STOP] && idle_mode_i |-> !run)
        else $error("unit runs in idle");

    AST_RUN_OUTSIDE_IDLE: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        ctrl[CTMC_BIT_ENABLE] && !idle_mode_i |-> run)
        else $error("unit stopped outside idle");

    AST_ROUTE_COMP: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        run && (flag1 != flag2) |-> (route_o == CTMC_ROUTE_COMP) == ctrl[CTMC_BIT_DELAY_GEN])
        else $error("bad route");

    AST_ROUTE_ADC: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        run && (flag1 != flag2) && !ctrl[CTMC_BIT_DELAY_GEN] |-> route_o == CTMC_ROUTE_ADC)
        else $error("current not routed to converter");

    AST_NO_PULSE_WITHOUT_DELAY: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        !ctrl[CTMC_BIT_DELAY_GEN] |=> !pulse)
        else $error("pulse without delay mode");

    AST_DELAY_START: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        run && ctrl[CTMC_BIT_DELAY_GEN] && dly_state == CTMC_DLY_IDLE && (acc1 || acc2) |=> dly_state == CTMC_DLY_CHARGE)
        else $error("charge not started");

    AST_CHARGE_CURRENT: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        run && dly_state == CTMC_DLY_CHARGE |-> current_on_o)
        else $error("no current while charging");

    AST_DELAY_PULSE: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        dly_state == CTMC_DLY_CHARGE && comp2_trip_i && run && ctrl[CTMC_BIT_DELAY_GEN] |=> pulse)
        else $error("no pulse");

    AST_PULSE_SINGLE: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        pulse |=> !pulse)
        else $error("pulse longer than one cycle");

    AST_EDGE_GATE: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        !ctrl[CTMC_BIT_EDGE_GATE] && !flag_wr |=> flag1 == $past(flag1))
        else $error("edge passed gate");

    AST_EDGE_GATE_SECOND: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        !ctrl[CTMC_BIT_EDGE_GATE] && !flag_wr |=> flag2 == $past(flag2))
        else $error("second edge passed gate");

    AST_EDGE_PASS: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        run && ctrl[CTMC_BIT_EDGE_GATE] && ev1 |=> flag1)
        else $error("open gate lost an edge");

    AST_EDGE_ORDER: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        ctrl[CTMC_BIT_EDGE_ORDER] && !flag1 && !flag2 && !flag_wr && !acc1 |=> !flag2)
        else $error("order broken");

    AST_ORDER_FREE: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        run && ctrl[CTMC_BIT_EDGE_GATE] && !ctrl[CTMC_BIT_EDGE_ORDER] && ev2 |=> flag2)
        else $error("second edge lost without order");

    AST_GROUND: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        source_ground_o == ctrl[CTMC_BIT_SRC_GROUND])
        else $error("ground mismatch");

    AST_TRIG_OFF: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        !ctrl[CTMC_BIT_TRIG_EN] ##1 !ctrl[CTMC_BIT_TRIG_EN] |-> !trigger_o)
        else $error("trigger while off");

    AST_TRIG_ON: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        run && ctrl[CTMC_BIT_TRIG_EN] && (flag1 ^ flag2) |=> trigger_o)
        else $error("trigger missing");

    AST_TRIM_FIELD: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        current_trim_o == ctrl[CTMC_TRIM_LSB +: CTMC_TRIM_W])
        else $error("trim mismatch");

    AST_DIODE: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        route_o == CTMC_ROUTE_DIODE |-> flag1 == flag2)
        else $error("diode with unequal flags");

    AST_DIODE_WHEN_EQUAL: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        run && flag1 == flag2 |-> route_o == CTMC_ROUTE_DIODE)
        else $error("equal flags without diode route");

    AST_FLAG_SET: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        acc1 |=> flag1)
        else $error("flag not set");

    AST_FLAG2_SET: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        acc2 |=> flag2)
        else $error("second flag not set");

    AST_SW_FLAG1: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        flag_wr && !acc1 |=> flag1 == $past(pwdata[CTMC_EDGE1_FLAG]))
        else $error("first flag write lost");

    AST_SW_FLAG2: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        flag_wr && !acc2 |=> flag2 == $past(pwdata[CTMC_EDGE2_FLAG]))
        else $error("second flag write lost");

    AST_CURRENT_ONE_FLAG: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        run && (flag1 ^ flag2) |-> current_on_o)
        else $error("current off between edges");

    AST_NO_CURRENT_OUTSIDE: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        run && flag1 == flag2 && dly_state != CTMC_DLY_CHARGE |-> !current_on_o)
        else $error("current outside edge window");
endmodule : ctmc_ctrl

// File: verilog/ctmc_pkg.sv
// Package with register map, field positions and reset values of the measurement control block.
package ctmc_pkg;
    localparam logic [11:0] CTMC_ADDR_CTRL = 12'h000;
    localparam logic [11:0] CTMC_ADDR_EDGE = 12'h004;
    localparam logic [11:0] CTMC_ADDR_STAT = 12'h008;
    localparam int CTMC_BIT_ENABLE = 15;
    localparam int CTMC_BIT_IDLE_STOP = 13;
    localparam int CTMC_BIT_DELAY_GEN = 12;
    localparam int CTMC_BIT_EDGE_GATE = 11;
    localparam int CTMC_BIT_EDGE_ORDER = 10;
    localparam int CTMC_BIT_SRC_GROUND = 9;
    localparam int CTMC_BIT_TRIG_EN = 8;
    localparam int CTMC_TRIM_LSB = 2;
    localparam int CTMC_TRIM_W = 6;
    localparam int CTMC_RANGE_LSB = 0;
    localparam int CTMC_RANGE_W = 2;
    localparam logic [15:0] CTMC_CTRL_WMASK = 16'hbfff;
    localparam logic [15:0] CTMC_CTRL_RESET = 16'h0000;
    localparam int CTMC_EDGE_SEL_W = 4;
    localparam int CTMC_EDGE_SRC_N = 16;
    localparam int CTMC_EXT_PINS = 13;
    localparam logic [3:0] CTMC_SEL_TIMER = 4'h0;
    localparam logic [3:0] CTMC_SEL_OCMP = 4'h1;
    localparam int CTMC_EDGE1_SEL_LSB = 0;
    localparam int CTMC_EDGE2_SEL_LSB = 4;
    localparam int CTMC_EDGE1_POL = 8;
    localparam int CTMC_EDGE2_POL = 9;
    localparam int CTMC_EDGE1_FLAG = 10;
    localparam int CTMC_EDGE2_FLAG = 11;
    localparam logic [1:0] CTMC_RANGE_5U5 = 2'h2;
    localparam logic [1:0] CTMC_RANGE_55U = 2'h3;
    typedef enum logic [1:0] {CTMC_ROUTE_OFF, CTMC_ROUTE_ADC, CTMC_ROUTE_COMP, CTMC_ROUTE_DIODE} ctmc_route_t;
    typedef enum {CTMC_DLY_IDLE, CTMC_DLY_CHARGE, CTMC_DLY_PULSE} ctmc_dly_state_t;
endpackage : ctmc_pkg

// File: verilog/ctmc_edge_det.sv
// Edge source selection and polarity-qualified edge detector for one edge channel.
`timescale 1ns/10ps
module ctmc_edge_det #(
    parameter int SRC_N = ctmc_pkg::CTMC_EDGE_SRC_N
) (
    input wire logic clk_sys_i,   // System clock.
    input wire logic rstn_i,      // Asynchronous reset, active low.
    input wire logic [SRC_N-1:0] src_i, // Candidate edge sources.
    input wire logic [ctmc_pkg::CTMC_EDGE_SEL_W-1:0] sel_i, // Source select.
    input wire logic pos_i,       // High selects rising edges.
    output logic event_o          // One-cycle edge event.
);
    import ctmc_pkg::*;
    logic raw;
    logic prev;
    logic [CTMC_EDGE_SEL_W-1:0] last_sel;
    logic last_pos;
    logic cfg_steady;
    assign raw = src_i[sel_i];
    // After a select or polarity change the stored sample is stale, so that cycle yields no event.
    assign cfg_steady = (sel_i == last_sel) && (pos_i == last_pos);
    // Reset values match the idle low sources and the reset edge configuration.
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prev <= 1'b0;
            last_sel <= {CTMC_EDGE_SEL_W{1'b0}};
            last_pos <= 1'b0;
        end else begin
            prev <= raw;
            last_sel <= sel_i;
            last_pos <= pos_i;
        end
    end
    assign event_o = cfg_steady & (pos_i ? (raw & ~prev) : (~raw & prev));
endmodule : ctmc_edge_det

// File: testbench/ctmc_far_model.sv
// Behavioural model of the edge sources and the delay comparator around the measurement block.
`timescale 1ns/10ps
module ctmc_far_model (
    input wire logic clk_sys_i,         // System clock.
    output logic timer_match_o,         // Timer match source.
    output logic ocmp_event_o,          // Output compare source.
    output logic [12:0] ext_edge_pin_o, // External edge pins.
    output logic comp2_trip_o           // Comparator trip level.
);
    logic [15:0] src = 16'h0000;
    initial comp2_trip_o = 1'b0;
    assign timer_match_o = src[0];
    assign ocmp_event_o = src[1];
    assign ext_edge_pin_o = src[14:2];
    // Sources are numbered as the edge select codes: 0 timer, 1 compare, 2 to 14 pins.
    task automatic pulse(input int idx, input int len);
        @(posedge clk_sys_i);
        src[idx] <= 1'b1;
        repeat (len) @(posedge clk_sys_i);
        src[idx] <= 1'b0;
    endtask : pulse
    task automatic trip(input logic lvl);
        @(posedge clk_sys_i);
        comp2_trip_o <= lvl;
    endtask : trip
endmodule : ctmc_far_model

// File: testbench/charge_time_meas_control_test.sv
// Self-checking testbench of the measurement control block.
`timescale 1ns/10ps
module charge_time_meas_control_test;
    import ctmc_pkg::*;
    logic clk_sys_i = 1'b0, rstn_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, idle_mode_i = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, timer_match, ocmp_event, comp2_trip;
    logic [12:0] ext_pins;
    logic current_on, src_gnd, pulse_out, trig, flag1, flag2;
    logic [5:0] trim;
    logic [1:0] range;
    ctmc_route_t route;
    int err_count = 0, samples_checked = 0;
    ctmc_far_model far (.clk_sys_i(clk_sys_i), .timer_match_o(timer_match), .ocmp_event_o(ocmp_event),
        .ext_edge_pin_o(ext_pins), .comp2_trip_o(comp2_trip));
    ctmc_ctrl dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .idle_mode_i(idle_mode_i), .timer_match_i(timer_match), .ocmp_event_i(ocmp_event),
        .ext_edge_pin_i(ext_pins), .comp2_trip_i(comp2_trip), .current_on_o(current_on),
        .source_ground_o(src_gnd), .route_o(route), .current_trim_o(trim), .current_range_o(range),
        .delay_pulse_out_o(pulse_out), .trigger_o(trig), .first_edge_flag_o(flag1), .second_edge_flag_o(flag2));
    initial begin
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
            err_count++;
        end
    endtask : chk
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys_i);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_count++;
            finish_test();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Callers look at outputs only after the access edge has settled.
        @(negedge clk_sys_i);
    endtask : apb
    // Writes control, then edge selects, polarities and both flags as given in e.
    task automatic cfg(input logic [15:0] c, input logic [15:0] e);
        apb(CTMC_ADDR_CTRL, 1'b1, {16'h0, c});
        apb(CTMC_ADDR_EDGE, 1'b1, {16'h0, e});
    endtask : cfg
    task automatic fire(input int idx);
        far.pulse(idx, 1);
        repeat (4) @(posedge clk_sys_i);
    endtask : fire
    task automatic t_regs();
        apb(CTMC_ADDR_CTRL, 1'b0, 32'h0);
        chk("ctrl reset", 32'h0, rd);
        apb(CTMC_ADDR_CTRL, 1'b1, 32'h0000ffff);
        apb(CTMC_ADDR_CTRL, 1'b0, 32'h0);
        chk("ctrl all ones", 32'h0000bfff, rd);
        chk("ground", 32'h1, {31'h0, src_gnd});
        chk("trim all ones", 32'h3f, {26'h0, trim});
        apb(CTMC_ADDR_CTRL, 1'b1, 32'h0000007c);
        chk("trim max", 32'h1f, {26'h0, trim});
        apb(CTMC_ADDR_CTRL, 1'b1, 32'h00000086);
        chk("trim min", 32'h21, {26'h0, trim});
        chk("range", {30'h0, CTMC_RANGE_5U5}, {30'h0, range});
        chk("ground off", 32'h0, {31'h0, src_gnd});
        apb(12'h00c, 1'b0, 32'h0);
        chk("unmapped", 32'h1, {31'h0, er});
        $display("test regs done");
    endtask : t_regs
    task automatic t_sequence();
        cfg(16'h8900, 16'h0310);
        fire(0);
        chk("flag1 hw", 32'h1, {31'h0, flag1});
        chk("current on", 32'h1, {31'h0, current_on});
        chk("route adc", {30'h0, CTMC_ROUTE_ADC}, {30'h0, route});
        chk("trigger", 32'h1, {31'h0, trig});
        fire(1);
        chk("flag2 hw", 32'h1, {31'h0, flag2});
        chk("current off", 32'h0, {31'h0, current_on});
        chk("trigger off", 32'h0, {31'h0, trig});
        cfg(16'h8800, 16'h0310);
        fire(0);
        chk("trigger masked", 32'h0, {31'h0, trig});
        cfg(16'h8000, 16'h0310);
        fire(0);
        chk("gate blocks", 32'h0, {31'h0, flag1});
        cfg(16'h0800, 16'h0310);
        fire(0);
        chk("disabled flag", 32'h0, {31'h0, flag1});
        chk("disabled current", 32'h0, {31'h0, current_on});
        $display("test sequence done");
    endtask : t_sequence
    task automatic t_order();
        cfg(16'h8c00, 16'h0310);
        fire(1);
        chk("edge2 early", 32'h0, {31'h0, flag2});
        fire(0);
        fire(1);
        chk("edge2 after 1", 32'h1, {31'h0, flag2});
        cfg(16'h8800, 16'h02e2);
        far.pulse(14, 2);
        repeat (4) @(posedge clk_sys_i);
        chk("pin12 edge2", 32'h1, {31'h0, flag2});
        chk("edge1 quiet", 32'h0, {31'h0, flag1});
        fire(2);
        chk("pin0 fall edge1", 32'h1, {31'h0, flag1});
        $display("test order done");
    endtask : t_order
    task automatic t_idle_delay();
        @(posedge clk_sys_i) idle_mode_i <= 1'b1;
        cfg(16'ha800, 16'h0310);
        fire(0);
        chk("idle stop", 32'h0, {31'h0, flag1});
        @(posedge clk_sys_i) idle_mode_i <= 1'b0;
        fire(0);
        chk("idle left", 32'h1, {31'h0, flag1});
        cfg(16'h9800, 16'h0310);
        fire(0);
        chk("route comp", {30'h0, CTMC_ROUTE_COMP}, {30'h0, route});
        chk("charging", 32'h1, {31'h0, current_on});
        far.trip(1'b1);
        @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        chk("delay pulse", 32'h1, {31'h0, pulse_out});
        @(negedge clk_sys_i);
        chk("pulse one cycle", 32'h0, {31'h0, pulse_out});
        far.trip(1'b0);
        cfg(16'h8002, 16'h0c10);
        chk("equal flags", 32'h0, {31'h0, current_on});
        chk("route diode", {30'h0, CTMC_ROUTE_DIODE}, {30'h0, route});
        apb(CTMC_ADDR_EDGE, 1'b1, 32'h00000410);
        chk("sw flag", 32'h1, {31'h0, current_on});
        $display("test idle and delay done");
    endtask : t_idle_delay
    initial begin
        repeat (16) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        t_regs();
        t_sequence();
        t_order();
        t_idle_delay();
        finish_test();
    end
endmodule : charge_time_meas_control_test
